/* rtl/flash_read_buffer_controller.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Stall flash transfers until initialization completes
// - Initialization reads index sector, captures protection
// - Protection blocks JTAG/debug; security hides secured sectors
// - Synchronous timing: standby after read, no abort
// - Asynchronous timing allows abort, speculation, dual buffer
// - One line holds 128 bits, four lanes
// - No buffering: every non-secured read starts flash read
// - Single buffer hit answers with zero waits
// - Different word starts read with wait states
// - Dual: primary hit copies to secondary, speculates
// - Invalidate lines on init, config, latch, index
// - Single-speculative once per miss; always-speculative every use
// - Reset default synchronous single buffer line
// - Programming uses whole 128-bit flash words
// - Eight small, eleven large sectors; 4096-bit pages
// - Small sectors from 0x2000_0000, large from 0x2001_0000
// - Index sector visible only with select bit
// - Refuse index erase once programmed
// - Insert programmed wait-state count plus one cycle per read
// - Above three waits speculation cannot hide latency
// - Byte-erasable 16 kB EEPROM reached only here
module flash_read_buffer_controller
	import flash_read_buffer_pkg::*;
(
	input  wire logic                                   clk,
	input  wire logic                                   sys_rst,
	input  wire logic                                   hsel,
	input  wire logic [31:0]                            haddr,
	input  wire logic [1:0]                             htrans,
	input  wire logic                                   hwrite,
	input  wire logic                                   hready,
	output var  logic [31:0]                            hrdata,
	output var  logic                                   hreadyout,
	output var  logic                                   hresp,
	input  wire logic                                   async_timing,
	input  wire flash_read_buffer_pkg::buf_mode_t       buf_mode,
	input  wire logic [3:0]                             read_wait_state_count,
	input  wire logic                                   index_sector_select,
	input  wire logic                                   cfg_access,
	input  wire logic                                   latch_read,
	input  wire logic                                   index_erase_req,
	output var  logic                                   erase_granted,
	output var  logic                                   erase_refused,
	output var  logic                                   jtag_flash_block,
	output var  logic                                   cpu_debug_disable,
	output var  logic [flash_read_buffer_pkg::TAG_W-1:0] flash_addr,
	output var  logic                                   flash_rd,
	output var  logic                                   flash_index_sel,
	output var  logic                                   flash_eeprom_sel,
	output var  logic                                   flash_standby,
	output var  logic                                   flash_abort,
	input  wire logic [flash_read_buffer_pkg::FLASH_WORD_BITS-1:0] flash_rdata
);
	import flash_read_buffer_pkg::*;

	state_t           q;
	state_t           d;
	logic             req;
	logic [TAG_W-1:0] req_tag;
	logic             req_eep;
	logic             req_idx;
	logic             req_secured;
	logic             dual;
	logic             done;
	logic [4:0]       sect;

	// ---------------------------------------------------------------
	// Request decode
	// ---------------------------------------------------------------
	assign req     = hsel && htrans[1] && hready && !hwrite;
	assign req_tag = haddr[19:4];
	assign req_eep = (haddr & EEPROM_MASK) == EEPROM_BASE;
	assign req_idx = index_sector_select && !req_eep;
	// Speculation only makes sense when reads can be abandoned
	assign dual    = async_timing && buf_mode[1];
	assign done    = q.cnt == read_wait_state_count;

	// Small sectors occupy bits 0..7 of the mask, large ones 8..18
	always_comb
	begin
		if (haddr[19:16] == 4'h0)
			sect = {2'b00, haddr[15:13]};
		else
			sect = 5'(haddr[19:16]) + 5'(SMALL_SECTORS - 1);
	end
	assign req_secured = q.sec_on && !req_eep && q.sec_mask[sect];

	function automatic logic [31:0] lane_of(input logic [FLASH_WORD_BITS-1:0] w, input logic [1:0] l);
		return w[l*BUS_WORD_BITS +: BUS_WORD_BITS];
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		d               = q;
		d.fl_abort      = 1'b0;
		d.erase_ok      = index_erase_req && !q.idx_prog;
		d.erase_refused = index_erase_req && q.idx_prog;
		case (q.st)
			S_INIT:
			begin
				d.hreadyout = 1'b0;
				d.cnt       = q.cnt + 4'h1;
				if (done)
				begin
					d.jtag_block = flash_rdata[IDX_JTAG_BIT];
					d.sec_on     = flash_rdata[IDX_SECURE_BIT];
					d.idx_prog   = flash_rdata[IDX_PROG_BIT];
					d.sec_mask   = flash_rdata[IDX_MASK_LSB +: SECTORS];
					d.fl_rd      = 1'b0;
					d.fl_idx     = 1'b0;
					d.fl_standby = 1'b1;
					d.pri.v      = 1'b0;
					d.sec.v      = 1'b0;
					d.hreadyout  = 1'b1;
					d.st         = S_IDLE;
				end
			end
			S_IDLE:
			begin
				d.fl_standby = 1'b1;
			end
			S_READ:
			begin
				d.cnt = q.cnt + 4'h1;
				if (done)
				begin
					d.hrdata     = lane_of(flash_rdata, q.lane);
					d.hreadyout  = 1'b1;
					d.fl_rd      = 1'b0;
					d.fl_idx     = 1'b0;
					d.fl_eep     = 1'b0;
					d.fl_standby = 1'b1;
					d.st         = S_IDLE;
					// Index words never stay in a line; EEPROM bytes simply bypass the lines
					if (q.fl_idx)
					begin
						d.pri.v = 1'b0;
						d.sec.v = 1'b0;
					end
					else if (!q.uncached && buf_mode != BUF_NONE)
						d.pri = '{v: 1'b1, tag: q.rd_tag, data: flash_rdata};
					if (!q.uncached && dual)
					begin
						// After a miss both speculative modes start one read ahead
						d.sec        = '{v: 1'b1, tag: q.rd_tag, data: flash_rdata};
						d.pri.v      = 1'b0;
						d.spec_one   = 1'b0;
						d.fl_addr    = q.rd_tag + TAG_W'(1);
						d.fl_rd      = 1'b1;
						d.fl_standby = 1'b0;
						d.cnt        = 4'h0;
						d.st         = S_SPEC;
					end
				end
			end
			S_SPEC:
			begin
				d.cnt = q.cnt + 4'h1;
				if (done)
				begin
					// Speculative data becomes the primary line
					d.pri        = '{v: 1'b1, tag: q.fl_addr, data: flash_rdata};
					d.fl_rd      = 1'b0;
					d.fl_standby = 1'b1;
					d.st         = S_IDLE;
				end
			end
			default:
			begin
				d.st = S_INIT;
			end
		endcase

		// Done after the state update, so a line filled on this same edge is dropped too
		if (cfg_access || latch_read)
		begin
			d.pri.v = 1'b0;
			d.sec.v = 1'b0;
		end

		// AHB address phase, served only when the controller is free or speculating
		if (req && (q.st == S_IDLE || q.st == S_SPEC) && q.hreadyout)
		begin
			d.lane     = haddr[3:2];
			d.rd_tag   = req_tag;
			d.uncached = req_idx || req_eep;
			if (req_secured)
			begin
				d.hrdata    = 32'h0000_0000;
				d.hreadyout = 1'b1;
			end
			else if (!d.uncached && buf_mode != BUF_NONE && d.pri.v && d.pri.tag == req_tag)
			begin
				d.hrdata    = lane_of(d.pri.data, haddr[3:2]);
				d.hreadyout = 1'b1;
				if (dual && (buf_mode == BUF_DUAL_ALL || q.spec_one) && q.st == S_IDLE)
				begin
					d.sec        = d.pri;
					d.pri.v      = 1'b0;
					d.spec_one   = 1'b0;
					d.fl_addr    = req_tag + TAG_W'(1);
					d.fl_rd      = 1'b1;
					d.fl_standby = 1'b0;
					d.cnt        = 4'h0;
					d.st         = S_SPEC;
				end
			end
			else if (!d.uncached && dual && d.sec.v && d.sec.tag == req_tag)
			begin
				d.hrdata    = lane_of(d.sec.data, haddr[3:2]);
				d.hreadyout = 1'b1;
			end
			else if (q.st == S_SPEC && !done && !d.uncached && q.fl_addr == req_tag)
			begin
				// Wanted word is already on its way: keep the running read
				d.hreadyout = 1'b0;
				d.st        = S_READ;
			end
			else
			begin
				if (q.st == S_SPEC && !done)
					d.fl_abort = 1'b1;
				d.fl_addr    = req_tag;
				d.fl_idx     = req_idx;
				d.fl_eep     = req_eep;
				d.fl_rd      = 1'b1;
				d.fl_standby = 1'b0;
				d.cnt        = 4'h0;
				d.spec_one   = 1'b1;
				d.hreadyout  = 1'b0;
				d.st         = S_READ;
			end
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q            <= '0;
			q.st         <= S_INIT;
			q.fl_rd      <= 1'b1;
			q.fl_idx     <= 1'b1;
			q.jtag_block <= 1'b1;
		end
		else
			q <= d;
	end

	assign hrdata            = q.hrdata;
	assign hreadyout         = q.hreadyout;
	assign hresp             = q.erase_ok & 1'b0;
	assign erase_granted     = q.erase_ok;
	assign erase_refused     = q.erase_refused;
	assign jtag_flash_block  = q.jtag_block;
	assign cpu_debug_disable = q.jtag_block;
	assign flash_addr        = q.fl_addr;
	assign flash_rd          = q.fl_rd;
	assign flash_index_sel   = q.fl_idx;
	assign flash_eeprom_sel  = q.fl_eep;
	assign flash_standby     = q.fl_standby;
	assign flash_abort       = q.fl_abort;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_init_stall: assert property (q.st == S_INIT |-> !hreadyout)
		else $error("bus ready during initialization");
	chk_init_end: assert property ((q.st == S_INIT && done) |=> (q.st == S_IDLE && !q.pri.v && !q.sec.v))
		else $error("lines valid after initialization");
	chk_sync_no_abort: assert property (!async_timing |-> !flash_abort)
		else $error("abort issued in synchronous timing");
	chk_sync_no_spec: assert property ((!async_timing && $stable(async_timing)) |=> q.st != S_SPEC)
		else $error("speculation in synchronous timing");
	chk_hit_zero_wait: assert property ((req && q.st == S_IDLE && q.hreadyout && !req_secured && !req_idx && !req_eep
		&& buf_mode == BUF_SINGLE && q.pri.v && q.pri.tag == req_tag && !cfg_access && !latch_read)
		|=> (hreadyout && !flash_rd && hrdata == lane_of($past(q.pri.data), $past(haddr[3:2]))))
		else $error("buffer hit not served without wait");
	chk_nobuf_read: assert property ((req && q.st == S_IDLE && q.hreadyout && !req_secured && buf_mode == BUF_NONE)
		|=> (flash_rd && !hreadyout && flash_addr == $past(req_tag)))
		else $error("unbuffered read did not start flash read");
	chk_wait_count: assert property ((q.st == S_READ && flash_rd && q.cnt == 4'h0 && read_wait_state_count == 4'h2
		&& $stable(read_wait_state_count)) |-> ##2 (q.st == S_READ && done) ##1 hreadyout)
		else $error("wait-state count not honoured");
	chk_invalidate: assert property ((cfg_access || latch_read) |=> (!q.pri.v && !q.sec.v))
		else $error("lines kept after configuration or latch access");
	chk_erase_refuse: assert property ((index_erase_req && q.idx_prog) |=> (erase_refused && !erase_granted))
		else $error("index erase not refused");
	chk_secured_zero: assert property ((req && q.st == S_IDLE && q.hreadyout && req_secured)
		|=> (hrdata == 32'h0000_0000 && hreadyout && !flash_rd))
		else $error("secured sector data returned");

endmodule

`default_nettype wire

/* inc/flash_read_buffer_pkg.sv */
package flash_read_buffer_pkg;

	// ---------------------------------------------------------------
	// Geometry and address map
	// ---------------------------------------------------------------
	localparam int          FLASH_WORD_BITS   = 128;
	localparam int          BUS_WORD_BITS     = 32;
	localparam int          FLASH_WORD_BYTES  = 16;
	localparam int          PAGE_BITS         = 4096;
	localparam int          PAGE_FLASH_WORDS  = 32;
	localparam int          SMALL_SECTORS     = 8;
	localparam int          LARGE_SECTORS     = 11;
	localparam int          SMALL_SECTOR_KB   = 8;
	localparam int          LARGE_SECTOR_KB   = 64;
	localparam int          SMALL_PAGES       = 16;
	localparam int          LARGE_PAGES       = 128;
	localparam int          SMALL_FIRST_NUM   = 11;
	localparam int          TAG_W             = 16;
	localparam int          SECTORS           = SMALL_SECTORS + LARGE_SECTORS;
	localparam logic [31:0] SMALL_BASE        = 32'h2000_0000;
	localparam logic [31:0] LARGE_BASE        = 32'h2001_0000;
	localparam logic [31:0] EEPROM_BASE       = 32'h2020_0000;
	localparam int          EEPROM_KB         = 16;
	localparam logic [31:0] EEPROM_MASK       = 32'hFFFF_C000;

	// ---------------------------------------------------------------
	// Index sector word layout
	// ---------------------------------------------------------------
	localparam int          IDX_JTAG_BIT      = 0;
	localparam int          IDX_SECURE_BIT    = 1;
	localparam int          IDX_PROG_BIT      = 2;
	localparam int          IDX_MASK_LSB      = 8;

	localparam logic [3:0]  SPEC_FULL_WST     = 4'h3;
	localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h1;

	typedef enum logic [1:0] {
		BUF_NONE     = 2'h0,
		BUF_SINGLE   = 2'h1,
		BUF_DUAL_ONE = 2'h2,
		BUF_DUAL_ALL = 2'h3
	} buf_mode_t;

	typedef enum logic [3:0] {
		S_INIT = 4'b0001,
		S_IDLE = 4'b0010,
		S_READ = 4'b0100,
		S_SPEC = 4'b1000
	} fsm_t;

	typedef struct packed {
		logic                       v;
		logic [TAG_W-1:0]           tag;
		logic [FLASH_WORD_BITS-1:0] data;
	} line_t;

	typedef struct packed {
		fsm_t                  st;
		logic [3:0]            cnt;
		logic [TAG_W-1:0]      rd_tag;
		logic [1:0]            lane;
		logic                  uncached;
		logic                  spec_one;
		line_t                 pri;
		line_t                 sec;
		logic [TAG_W-1:0]      fl_addr;
		logic                  fl_rd;
		logic                  fl_idx;
		logic                  fl_eep;
		logic                  fl_standby;
		logic                  fl_abort;
		logic [31:0]           hrdata;
		logic                  hreadyout;
		logic                  jtag_block;
		logic                  sec_on;
		logic [SECTORS-1:0]    sec_mask;
		logic                  idx_prog;
		logic                  erase_ok;
		logic                  erase_refused;
	} state_t;

endpackage

/* verif/flash_array_model.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_array_model
	import flash_read_buffer_pkg::*;
(
	input  wire logic                                              clk,
	input  wire logic [flash_read_buffer_pkg::TAG_W-1:0]           flash_addr,
	input  wire logic                                              flash_rd,
	input  wire logic                                              flash_index_sel,
	input  wire logic                                              flash_eeprom_sel,
	input  wire logic [31:0]                                       idx_word,
	output var  logic [flash_read_buffer_pkg::FLASH_WORD_BITS-1:0] flash_rdata
);
	import flash_read_buffer_pkg::*;

	logic [FLASH_WORD_BITS-1:0] word;
	logic [FLASH_WORD_BITS-1:0] last_q;

	// ---------------------------------------------------------------
	// Array contents
	// ---------------------------------------------------------------
	// Outside index reads every lane carries its own number, so a wrong lane select shows up
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			word[32*i +: 32] = {flash_addr, flash_eeprom_sel ? 8'hEE : 8'h5A, 6'h00, 2'(i)};
		if (flash_index_sel)
			word[31:0] = idx_word;
	end

	always_ff @(posedge clk)
		if (flash_rd)
			last_q <= word;

	// A released output shows inverted data, never a stale copy
	assign flash_rdata = flash_rd ? word : ~last_q;

endmodule

`default_nettype wire

/* verif/flash_read_buffer_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module flash_read_buffer_controller_tb_top;
	import flash_read_buffer_pkg::*;

	typedef struct packed {
		logic        a;
		logic [1:0]  m;
		logic [3:0]  w;
		logic        inv;
		logic [3:0]  gap;
		logic [31:0] addr;
		logic [3:0]  wt;
	} row_t;

	logic                       clk = 1'b0;
	logic                       sys_rst;
	logic                       hsel;
	logic [31:0]                haddr;
	logic [1:0]                 htrans;
	logic                       hwrite;
	wire                        hready;
	logic [31:0]                hrdata;
	logic                       hreadyout;
	logic                       hresp;
	logic                       async_timing;
	buf_mode_t                  buf_mode;
	logic [3:0]                 read_wait_state_count;
	logic                       index_sector_select;
	logic                       cfg_access;
	logic                       latch_read;
	logic                       index_erase_req;
	logic                       erase_granted;
	logic                       erase_refused;
	logic                       jtag_flash_block;
	logic                       cpu_debug_disable;
	logic [TAG_W-1:0]           flash_addr;
	logic                       flash_rd;
	logic                       flash_index_sel;
	logic                       flash_eeprom_sel;
	logic                       flash_standby;
	logic                       flash_abort;
	logic [FLASH_WORD_BITS-1:0] flash_rdata;
	logic [31:0]                idx_word;
	logic                       eep_seen;
	logic                       abort_seen;
	int                         n_fail = 0;
	int                         compares = 0;
	int                         waits;
	row_t                       rows [16];

	// Single slave on the bus, so the bus ready is our own ready
	assign hready = hreadyout;

	flash_read_buffer_controller u_flash_read_buffer_controller (
		.clk                   (clk),
		.sys_rst               (sys_rst),
		.hsel                  (hsel),
		.haddr                 (haddr),
		.htrans                (htrans),
		.hwrite                (hwrite),
		.hready                (hready),
		.hrdata                (hrdata),
		.hreadyout             (hreadyout),
		.hresp                 (hresp),
		.async_timing          (async_timing),
		.buf_mode              (buf_mode),
		.read_wait_state_count (read_wait_state_count),
		.index_sector_select   (index_sector_select),
		.cfg_access            (cfg_access),
		.latch_read            (latch_read),
		.index_erase_req       (index_erase_req),
		.erase_granted         (erase_granted),
		.erase_refused         (erase_refused),
		.jtag_flash_block      (jtag_flash_block),
		.cpu_debug_disable     (cpu_debug_disable),
		.flash_addr            (flash_addr),
		.flash_rd              (flash_rd),
		.flash_index_sel       (flash_index_sel),
		.flash_eeprom_sel      (flash_eeprom_sel),
		.flash_standby         (flash_standby),
		.flash_abort           (flash_abort),
		.flash_rdata           (flash_rdata)
	);

	flash_array_model u_flash_array_model (
		.clk              (clk),
		.flash_addr       (flash_addr),
		.flash_rd         (flash_rd),
		.flash_index_sel  (flash_index_sel),
		.flash_eeprom_sel (flash_eeprom_sel),
		.idx_word         (idx_word),
		.flash_rdata      (flash_rdata)
	);

	always #5 clk = ~clk;

	// ---------------------------------------------------------------
	// Compare and bus tasks
	// ---------------------------------------------------------------
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chkn(input string nm, input int e, input int g);
		compares++;
		if (g != e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	function automatic logic [31:0] expect_of(input logic [31:0] a);
		if (idx_word[1] && idx_word[8] && a[31:13] == 19'h1_0000)
			return 32'h0000_0000;
		return {a[19:4], (a & EEPROM_MASK) == EEPROM_BASE ? 8'hEE : 8'h5A, 6'h00, a[3:2]};
	endfunction

	task automatic results();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Entered at a falling edge; the address stays up until the next call or idle
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input int wt);
		int n;
		hsel = 1'b1;
		htrans = 2'h2;
		haddr = a;
		n = 0;
		while (hreadyout !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		waits = 0;
		eep_seen = 1'b0;
		abort_seen = 1'b0;
		@(negedge clk);
		while (hreadyout !== 1'b1 && waits < 100)
		begin
			eep_seen |= flash_eeprom_sel;
			abort_seen |= flash_abort;
			waits++;
			@(negedge clk);
		end
		chk32("hrdata", e, hrdata);
		chk1("hresp", 1'b0, hresp);
		chkn("waits", wt, waits);
	endtask

	task automatic reset_dut(input logic [31:0] iw);
		int n;
		sys_rst = 1'b1;
		htrans = 2'h0;
		idx_word = iw;
		repeat (8) @(negedge clk);
		chk1("hreadyout", 1'b0, hreadyout);
		chk1("jtag_block", 1'b1, jtag_flash_block);
		sys_rst = 1'b0;
		n = 0;
		while (hreadyout !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk1("init_stall", 1'b1, n > 0 && n < 100);
		chk1("jtag_block", iw[0], jtag_flash_block);
		chk1("debug_off", iw[0], cpu_debug_disable);
	endtask

	task automatic erase(input logic ok);
		htrans = 2'h0;
		index_erase_req = 1'b1;
		@(negedge clk);
		index_erase_req = 1'b0;
		chk1("granted", ok, erase_granted);
		chk1("refused", !ok, erase_refused);
		@(negedge clk);
		chk1("answer_len", 1'b0, erase_granted | erase_refused);
	endtask

	task automatic pulse_inv(input logic latch);
		htrans = 2'h0;
		cfg_access = !latch;
		latch_read = latch;
		@(negedge clk);
		cfg_access = 1'b0;
		latch_read = 1'b0;
		repeat (8) @(negedge clk);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		// Read-only stimulus: nothing is programmed, so no unerased sector is ever written
		{sys_rst, hsel, haddr, htrans, hwrite} = {1'b1, 1'b0, 32'h0000_0000, 2'h0, 1'b0};
		{async_timing, read_wait_state_count, index_sector_select} = {1'b0, 4'h2, 1'b0};
		{cfg_access, latch_read, index_erase_req} = 3'h0;
		buf_mode = BUF_SINGLE;
		rows[0]  = '{0, 1, 2, 0, 0, 32'h2000_2000, 3};
		rows[1]  = '{0, 1, 2, 0, 0, 32'h2000_200C, 0};
		rows[2]  = '{0, 1, 2, 0, 0, 32'h2000_2004, 0};
		rows[3]  = '{0, 1, 2, 1, 0, 32'h2000_2008, 3};
		rows[4]  = '{0, 1, 2, 0, 0, 32'h2001_0040, 3};
		rows[5]  = '{0, 1, 2, 0, 0, 32'h2000_0010, 0};
		rows[6]  = '{0, 0, 2, 1, 0, 32'h2000_2000, 3};
		rows[7]  = '{0, 0, 2, 0, 0, 32'h2000_2004, 3};
		rows[8]  = '{0, 1, 5, 1, 0, 32'h2001_0040, 6};
		rows[9]  = '{1, 3, 2, 1, 0, 32'h2002_0100, 3};
		rows[10] = '{1, 3, 2, 0, 6, 32'h2002_0110, 0};
		rows[11] = '{1, 3, 2, 0, 6, 32'h2002_0120, 0};
		rows[12] = '{1, 2, 2, 1, 0, 32'h2003_0200, 3};
		rows[13] = '{1, 2, 2, 0, 6, 32'h2003_0214, 0};
		rows[14] = '{0, 3, 2, 1, 0, 32'h2002_0100, 3};
		rows[15] = '{0, 3, 2, 0, 6, 32'h2002_0110, 3};
		reset_dut(32'h0000_0107);
		foreach (rows[i])
		begin
			if (rows[i].inv)
			begin
				async_timing = rows[i].a;
				buf_mode = buf_mode_t'(rows[i].m);
				read_wait_state_count = rows[i].w;
				pulse_inv(1'b0);
			end
			if (rows[i].gap != 0)
			begin
				htrans = 2'h0;
				repeat (rows[i].gap) @(negedge clk);
			end
			rd(rows[i].addr, expect_of(rows[i].addr), rows[i].wt);
			if (!rows[i].a)
				chk1("standby", 1'b1, flash_standby);
			$display("row %0d done", i);
		end
		// Asynchronous dual buffering: a miss during speculation aborts it, a hit on it waits
		async_timing = 1'b1;
		buf_mode = BUF_DUAL_ALL;
		pulse_inv(1'b0);
		rd(32'h2004_0000, expect_of(32'h2004_0000), 3);
		rd(32'h2005_0000, expect_of(32'h2005_0000), 3);
		chk1("abort", 1'b1, abort_seen);
		rd(32'h2005_0010, expect_of(32'h2005_0010), 2);
		chk1("abort", 1'b0, abort_seen);
		$display("test abort done");
		rd(32'h2000_2000, expect_of(32'h2000_2000), 3);
		pulse_inv(1'b1);
		rd(32'h2000_2004, expect_of(32'h2000_2004), 3);
		htrans = 2'h0;
		index_sector_select = 1'b1;
		@(negedge clk);
		rd(32'h2001_0040, idx_word, 3);
		rd(32'h2001_0040, idx_word, 3);
		htrans = 2'h0;
		index_sector_select = 1'b0;
		@(negedge clk);
		rd(32'h2020_0010, expect_of(32'h2020_0010), 3);
		chk1("eeprom_sel", 1'b1, eep_seen);
		$display("test index and eeprom done");
		erase(1'b0);
		reset_dut(32'h0000_0000);
		erase(1'b1);
		rd(32'h2000_0010, expect_of(32'h2000_0010), 3);
		htrans = 2'h0;
		$display("test second reset done");
		results();
	end

	// A few hundred cycles cover every test; the limit of 30000 cycles is over a hundred times that
	initial
	begin
		#300us;
		n_fail++;
		results();
	end

endmodule

`default_nettype wire
